// [core/fifo_port_pkg.sv]
// shared constants and types for the asynchronous slave fifo port
// assumes both ends run from one 100 MHz ref_clk
package fifo_port_pkg;
    localparam int DATA_W      = 8;
    localparam int SEL_W       = 2;
    localparam int FIFO_COUNT  = 4;
    localparam int FIFO_DEPTH  = 16;
    localparam int PTR_W       = 4;
    localparam int CLK_PERIOD_NS = 10;
    // least strobe pulse widths, figures in ns
    localparam int STROBE_LOW_NS  = 50;
    localparam int STROBE_HIGH_NS = 50;
    localparam int STROBE_LOW_CYC =
        (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STROBE_HIGH_CYC =
        (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // margin over least widths covers the device's sync flops
    localparam int STROBE_MARGIN_CYC = 4;
    localparam int SEL_SETUP_CYC     = 2;
    localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
    localparam logic [PTR_W:0]    PTR_RESET  = 5'h00;
    typedef logic [DATA_W-1:0] data_t;
    typedef logic [SEL_W-1:0]  sel_t;
    typedef logic [PTR_W:0]    count_t;
endpackage

// [core/fifo_port_if.sv]
// strobe interface between the external master and the fifo port
// all control strobes are active low; data bus resolved from enables
`timescale 1ns/1ns
`default_nettype none
interface fifo_port_if;
    import fifo_port_pkg::*;
    logic  fifoChipSelect_n;
    logic  fifoOutputEnable_n;
    logic  fifoReadStrobe_n;
    logic  fifoWriteStrobe_n;
    logic  packetCommitStrobe_n;
    sel_t  fifoSelectBits;
    data_t devData;
    logic  devDataOe_n;
    data_t hostData;
    logic  hostDataOe_n;
    data_t busData;
    // wire level of the shared bus: whoever enables drives it
    assign busData = !devDataOe_n ? devData :
                     (!hostDataOe_n ? hostData : DATA_RESET);
    modport device (
        input  fifoChipSelect_n, fifoOutputEnable_n, fifoReadStrobe_n,
        input  fifoWriteStrobe_n, packetCommitStrobe_n, fifoSelectBits,
        input  busData,
        output devData, devDataOe_n
    );
    modport master (
        output fifoChipSelect_n, fifoOutputEnable_n, fifoReadStrobe_n,
        output fifoWriteStrobe_n, packetCommitStrobe_n, fifoSelectBits,
        output hostData, hostDataOe_n,
        input  busData
    );
endinterface
`default_nettype wire

// [core/fifo_port_device.sv]
// device end: four endpoint fifos behind the strobe port
// assumes the master keeps the strobe ordering rules
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - oe before read shows prior word
// - read needs chip select and strobe
// - read edge drives word at pointer
// - data driven only while oe active
// - oe and read may share one line
// - drive word first, then advance pointer
// - chip select precedes and spans write
// - write release captures word, advances
// - flag updates from write release
// - write pointer post incremented
// - commit strobe commits written bytes
// - commit never with write strobe
// - select bits steady during commit
// - select bits choose target fifo
module fifo_port_device #(
    parameter int DEPTH = fifo_port_pkg::FIFO_DEPTH
) (
    input  wire logic                  ref_clk,
    input  wire logic                  nrst,
    fifo_port_if.device                port,
    // device side: in fifo drain/fill seen from inside the chip
    input  wire logic                  loadValid,
    input  wire fifo_port_pkg::sel_t   loadSel,
    input  wire fifo_port_pkg::data_t  loadData,
    output logic                       loadReady,
    input  wire logic                  commitAck,
    output logic                       packetValid,
    output fifo_port_pkg::sel_t        packetSel,
    output fifo_port_pkg::count_t      packetLen,
    output logic [fifo_port_pkg::FIFO_COUNT-1:0] emptyFlag,
    output logic [fifo_port_pkg::FIFO_COUNT-1:0] fullFlag
);
    import fifo_port_pkg::*;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [5+SEL_W+DATA_W-1:0] syncA_q;
    logic [5+SEL_W+DATA_W-1:0] syncB_q;
    logic  cs, oe, rd, wr, pe;
    sel_t  sel;
    data_t din;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            // idle pins read as zero once inverted: no false edge at release
            syncA_q <= '0;
            syncB_q <= '0;
        end else begin
            syncA_q <= {~port.fifoChipSelect_n, ~port.fifoOutputEnable_n,
                        ~port.fifoReadStrobe_n, ~port.fifoWriteStrobe_n,
                        ~port.packetCommitStrobe_n, port.fifoSelectBits,
                        port.busData};
            syncB_q <= syncA_q;
        end
    end
    assign {cs, oe, rd, wr, pe, sel, din} = syncB_q;

    logic rdPrev_q, wrPrev_q, pePrev_q;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rdPrev_q <= 1'b0;
            wrPrev_q <= 1'b0;
            pePrev_q <= 1'b0;
        end else begin
            rdPrev_q <= rd && cs;
            wrPrev_q <= wr && cs;
            pePrev_q <= pe && cs;
        end
    end
    logic rdStart, wrRelease, peStart;
    assign rdStart   = rd && cs && !rdPrev_q;
    assign wrRelease = wrPrev_q && !wr;
    assign peStart   = pe && cs && !pePrev_q && !wr;

    // ----------------------------------------
    // endpoint storage
    // ----------------------------------------
    data_t  mem [FIFO_COUNT][DEPTH];
    logic [PTR_W-1:0] rdPtr_q [FIFO_COUNT];
    logic [PTR_W-1:0] wrPtr_q [FIFO_COUNT];
    count_t level_q [FIFO_COUNT];
    count_t pending_q [FIFO_COUNT];
    sel_t   wrSel_q;

    function automatic logic [PTR_W-1:0] bump(input logic [PTR_W-1:0] p);
        return (p == PTR_W'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    // a full fifo refuses the word rather than wrapping over unread data
    function automatic logic isFull(input count_t lvl);
        return lvl == count_t'(DEPTH);
    endfunction

    logic hostWrite, hostRead, intLoad;
    assign hostWrite = wrRelease && !isFull(level_q[wrSel_q]);
    assign hostRead  = rdStart && (level_q[sel] != '0);
    // inside load is held off while a host write lands this cycle
    assign loadReady = !hostWrite && !isFull(level_q[loadSel]);
    assign intLoad   = loadValid && loadReady;

    // ----------------------------------------
    // per-fifo decode of the pointer events
    // ----------------------------------------
    logic [FIFO_COUNT-1:0] wrHit;
    logic [FIFO_COUNT-1:0] loadHit;
    logic [FIFO_COUNT-1:0] rdHit;
    logic [FIFO_COUNT-1:0] peHit;
    always_comb begin
        for (int i = 0; i < FIFO_COUNT; i++) begin
            wrHit[i]   = hostWrite && (wrSel_q == sel_t'(i));
            loadHit[i] = intLoad && !hostWrite && (loadSel == sel_t'(i));
            rdHit[i]   = hostRead && (sel == sel_t'(i));
            // a refused commit keeps its byte count for a later one
            peHit[i]   = peStart && !packetValid && (sel == sel_t'(i));
        end
    end

    // select captured while the write strobe is live, so a release
    // still lands in the fifo that was addressed during the strobe
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            wrSel_q <= '0;
        end else if (wr && cs) begin
            wrSel_q <= sel;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (hostWrite) begin
            mem[wrSel_q][wrPtr_q[wrSel_q]] <= din;
        end else if (intLoad) begin
            mem[loadSel][wrPtr_q[loadSel]] <= loadData;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < FIFO_COUNT; i++) begin
                rdPtr_q[i]   <= '0;
                wrPtr_q[i]   <= '0;
                level_q[i]   <= PTR_RESET;
                pending_q[i] <= PTR_RESET;
            end
        end else begin
            for (int i = 0; i < FIFO_COUNT; i++) begin
                if (wrHit[i] || loadHit[i]) begin
                    wrPtr_q[i] <= bump(wrPtr_q[i]);
                end
                if (rdHit[i]) begin
                    rdPtr_q[i] <= bump(rdPtr_q[i]);
                end
                level_q[i] <= level_q[i] + count_t'(wrHit[i] || loadHit[i])
                              - count_t'(rdHit[i]);
                if (peHit[i]) begin
                    pending_q[i] <= '0;
                end else if (wrHit[i]) begin
                    pending_q[i] <= pending_q[i] + 1'b1;
                end
            end
        end
    end

    // ----------------------------------------
    // read data and bus drive
    // ----------------------------------------
    data_t rdData_q;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rdData_q <= DATA_RESET;
        end else if (hostRead) begin
            // word latched before pointer moves; held for oe-only cycles
            rdData_q <= mem[sel][rdPtr_q[sel]];
        end
    end
    assign port.devData     = rdData_q;
    assign port.devDataOe_n = !(oe && cs);

    // ----------------------------------------
    // packet commit towards the usb side
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            packetValid <= 1'b0;
            packetSel   <= '0;
            packetLen   <= PTR_RESET;
        end else if (peStart && !packetValid) begin
            packetValid <= 1'b1;
            packetSel   <= sel;
            packetLen   <= pending_q[sel];
        end else if (commitAck) begin
            packetValid <= 1'b0;
        end
    end

    // ----------------------------------------
    // status flags
    // ----------------------------------------
    always_comb begin
        for (int i = 0; i < FIFO_COUNT; i++) begin
            emptyFlag[i] = (level_q[i] == '0);
            fullFlag[i]  = isFull(level_q[i]);
        end
    end
endmodule
`default_nettype wire

// [core/fifo_port_master.sv]
// master end: drives strobes with least pulse widths from ref_clk
// assumes the device end samples pins through synchronisers
`timescale 1ns/1ns
`default_nettype none
module fifo_port_master (
    input  wire logic                  ref_clk,
    input  wire logic                  nrst,
    fifo_port_if.master                port,
    input  wire logic                  reqValid,
    input  wire logic [1:0]            reqKind,
    input  wire fifo_port_pkg::sel_t   reqSel,
    input  wire fifo_port_pkg::data_t  reqData,
    output logic                       reqReady,
    output logic                       rspValid,
    output fifo_port_pkg::data_t       rspData
);
    import fifo_port_pkg::*;
    // reqKind: 0 read, 1 write, 2 packet commit
    typedef enum logic [1:0] {IDLE, SETUP, ACTIVE, RECOVER} phase_t;
    localparam int HOLD_CYC = STROBE_LOW_CYC + STROBE_MARGIN_CYC;
    phase_t phase_q;
    logic [1:0] kind_q;
    logic [7:0] cnt_q;
    sel_t  sel_q;
    data_t data_q;

    assign reqReady = (phase_q == IDLE);

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            phase_q <= IDLE;
            cnt_q   <= '0;
            kind_q  <= '0;
            sel_q   <= '0;
            data_q  <= DATA_RESET;
        end else begin
            unique case (phase_q)
                IDLE: if (reqValid) begin
                    phase_q <= SETUP;
                    kind_q  <= reqKind;
                    sel_q   <= reqSel;
                    data_q  <= reqData;
                    cnt_q   <= 8'(SEL_SETUP_CYC);
                end
                SETUP: if (cnt_q == '0) begin
                    phase_q <= ACTIVE;
                    cnt_q   <= 8'(HOLD_CYC);
                end else begin
                    cnt_q <= cnt_q - 1'b1;
                end
                ACTIVE: if (cnt_q == '0) begin
                    phase_q <= RECOVER;
                    cnt_q   <= 8'(STROBE_HIGH_CYC + STROBE_MARGIN_CYC);
                end else begin
                    cnt_q <= cnt_q - 1'b1;
                end
                RECOVER: if (cnt_q == '0) begin
                    phase_q <= IDLE;
                end else begin
                    cnt_q <= cnt_q - 1'b1;
                end
            endcase
        end
    end

    logic busy, act;
    assign busy = (phase_q != IDLE);
    assign act  = (phase_q == ACTIVE);
    // chip select spans setup through recovery, framing each strobe
    assign port.fifoChipSelect_n     = !busy;
    // oe tied to the read strobe timing
    assign port.fifoOutputEnable_n   = !(act && kind_q == 2'h0);
    assign port.fifoReadStrobe_n     = !(act && kind_q == 2'h0);
    assign port.fifoWriteStrobe_n    = !(act && kind_q == 2'h1);
    // commit only as its own transfer, never beside a write strobe
    assign port.packetCommitStrobe_n = !(act && kind_q == 2'h2);
    assign port.fifoSelectBits       = sel_q;
    assign port.hostData             = data_q;
    assign port.hostDataOe_n         = !(busy && kind_q == 2'h1);

    data_t busA_q, busB_q;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            busA_q   <= DATA_RESET;
            busB_q   <= DATA_RESET;
            rspValid <= 1'b0;
            rspData  <= DATA_RESET;
        end else begin
            busA_q   <= port.busData;
            busB_q   <= busA_q;
            rspValid <= act && kind_q == 2'h0 && cnt_q == '0;
            if (act && kind_q == 2'h0 && cnt_q == '0) begin
                rspData <= busB_q;
            end
        end
    end
endmodule
`default_nettype wire

// [tb/fifo_port_properties.sv]
// assertions on the strobe interface between master and device ends
// assumes one ref_clk domain, nrst active low, signals from the interface
`timescale 1ns/1ns
`default_nettype none
module fifo_port_properties (
    input wire logic                 ref_clk,
    input wire logic                 nrst,
    input wire logic                 fifoChipSelect_n,
    input wire logic                 fifoOutputEnable_n,
    input wire logic                 fifoReadStrobe_n,
    input wire logic                 fifoWriteStrobe_n,
    input wire logic                 packetCommitStrobe_n,
    input wire fifo_port_pkg::sel_t  fifoSelectBits,
    input wire logic                 devDataOe_n,
    input wire fifo_port_pkg::data_t hostData,
    input wire logic                 hostDataOe_n
);
    import fifo_port_pkg::*;
    logic oeAct;
    assign oeAct = !fifoOutputEnable_n && !fifoChipSelect_n;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);
    // ----------------------------------------
    // named steps
    // ----------------------------------------
    sequence rdStart;
        $fell(fifoReadStrobe_n);
    endsequence
    sequence wrStart;
        $fell(fifoWriteStrobe_n);
    endsequence
    // device sees the shared strobe two sync flops after it falls
    sequence devDrives;
        ##2 !devDataOe_n;
    endsequence
    sequence pktHeld;
        !packetCommitStrobe_n ##1 !packetCommitStrobe_n;
    endsequence
    // ----------------------------------------
    // properties
    // ----------------------------------------
    // device enable lags the pins by its two sync flops
    oe_follow_a: assert property (!devDataOe_n |->
        $past(oeAct, 2) || $past(oeAct, 3)) else $error("bus driven w/o oe");
    oe_drive_a: assert property (oeAct [*4] |-> !devDataOe_n)
        else $error("oe held but bus not driven");
    cs_before_rd_a: assert property (rdStart |->
        $past(!fifoChipSelect_n)) else $error("read strobe without select");
    cs_before_wr_a: assert property (wrStart |->
        $past(!fifoChipSelect_n)) else $error("write strobe without select");
    rd_drive_a: assert property (rdStart |-> devDrives)
        else $error("shared strobe did not drive the bus");
    cs_spans_wr_a: assert property (!fifoWriteStrobe_n |->
        !fifoChipSelect_n) else $error("select dropped during write");
    bus_single_a: assert property (devDataOe_n || hostDataOe_n)
        else $error("both ends drive the bus");
    host_data_a: assert property (!fifoWriteStrobe_n |->
        !hostDataOe_n && $stable(hostData)) else $error("write data moved");
    no_overlap_a: assert property (fifoWriteStrobe_n ||
        packetCommitStrobe_n) else $error("commit with write strobe");
    commit_gap_a: assert property ($fell(packetCommitStrobe_n) |->
        $past(fifoWriteStrobe_n, 1) && $past(fifoWriteStrobe_n, 5))
        else $error("commit too soon after write");
    sel_steady_a: assert property (pktHeld |->
        $stable(fifoSelectBits)) else $error("select moved in commit");
    sel_setup_a: assert property ($fell(fifoReadStrobe_n) ||
        $fell(fifoWriteStrobe_n) || $fell(packetCommitStrobe_n) |->
        $stable(fifoSelectBits)) else $error("select moved at strobe");
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// self-checking bench: master and device ends joined by the interface
// assumes the package, interface and both ends are compiled first
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import fifo_port_pkg::*;
    localparam int DEPTH = FIFO_DEPTH;
    logic        ref_clk = 1'b0;
    logic        nrst = 1'b0;
    logic        reqValid = 1'b0;
    logic [1:0]  reqKind = 2'h0;
    sel_t        reqSel = 2'h0;
    data_t       reqData = 8'h00;
    logic        loadValid = 1'b0;
    sel_t        loadSel = 2'h0;
    data_t       loadData = 8'h00;
    logic        commitAck = 1'b0;
    logic        reqReady, rspValid, loadReady, packetValid;
    data_t       rspData, lastRd;
    sel_t        packetSel;
    count_t      packetLen;
    logic [3:0]  emptyFlag, fullFlag;
    logic [7:0]  pend = 8'h00;
    logic [31:0] rngQ = 32'h00004CE9;
    data_t       q[4][$];
    int          nMismatch = 0;
    int          nChecks = 0;
    int          cycles = 0;
    fifo_port_if u_fifo_port_if ();
    fifo_port_device #(.DEPTH(DEPTH)) u_fifo_port_device (.ref_clk(ref_clk),
        .nrst(nrst), .port(u_fifo_port_if.device), .loadValid(loadValid),
        .loadSel(loadSel), .loadData(loadData), .loadReady(loadReady),
        .commitAck(commitAck), .packetValid(packetValid),
        .packetSel(packetSel), .packetLen(packetLen),
        .emptyFlag(emptyFlag), .fullFlag(fullFlag));
    fifo_port_master u_fifo_port_master (.ref_clk(ref_clk), .nrst(nrst),
        .port(u_fifo_port_if.master), .reqValid(reqValid),
        .reqKind(reqKind), .reqSel(reqSel), .reqData(reqData),
        .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData));
    fifo_port_properties u_props (.ref_clk(ref_clk), .nrst(nrst),
        .fifoChipSelect_n(u_fifo_port_if.fifoChipSelect_n),
        .fifoOutputEnable_n(u_fifo_port_if.fifoOutputEnable_n),
        .fifoReadStrobe_n(u_fifo_port_if.fifoReadStrobe_n),
        .fifoWriteStrobe_n(u_fifo_port_if.fifoWriteStrobe_n),
        .packetCommitStrobe_n(u_fifo_port_if.packetCommitStrobe_n),
        .fifoSelectBits(u_fifo_port_if.fifoSelectBits),
        .devDataOe_n(u_fifo_port_if.devDataOe_n),
        .hostData(u_fifo_port_if.hostData),
        .hostDataOe_n(u_fifo_port_if.hostDataOe_n));
    always #5 ref_clk = ~ref_clk;
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic completeRun();
        if (nMismatch == 0 && nChecks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // watchdog: 73 transfers of some 25 cycles each
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 10000) begin
            nMismatch++;
            completeRun();
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        nChecks++;
        if (seen !== exp) begin
            nMismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    function automatic data_t rnd8();
        rngQ = rngQ ^ (rngQ << 13);
        rngQ = rngQ ^ (rngQ >> 17);
        rngQ = rngQ ^ (rngQ << 5);
        return rngQ[7:0];
    endfunction
    task automatic flags();
        logic [3:0] e, f;
        for (int i = 0; i < 4; i++) begin
            e[i] = q[i].size() == 0;
            f[i] = q[i].size() == DEPTH;
        end
        check({4'h0, emptyFlag}, {4'h0, e});
        check({4'h0, fullFlag}, {4'h0, f});
    endtask
    task automatic waitIdle();
        @(negedge ref_clk);
        while (reqReady !== 1'b1) @(negedge ref_clk);
    endtask
    // internal fill, so reads have data the host never wrote
    task automatic load(input sel_t s, input data_t d);
        @(negedge ref_clk);
        while (loadReady !== 1'b1) @(negedge ref_clk);
        @(posedge ref_clk);
        loadValid <= 1'b1;
        loadSel <= s;
        loadData <= d;
        @(posedge ref_clk);
        loadValid <= 1'b0;
        q[s].push_back(d);
    endtask
    task automatic req(input logic [1:0] k, input sel_t s, input data_t d);
        waitIdle();
        @(posedge ref_clk);
        reqValid <= 1'b1;
        reqKind <= k;
        reqSel <= s;
        reqData <= d;
        @(posedge ref_clk);
        reqValid <= 1'b0;
        if (k == 2'h0) begin
            while (rspValid !== 1'b1) @(negedge ref_clk);
            if (q[s].size() > 0) lastRd = q[s].pop_front();
            check(rspData, lastRd);
        end
        if (k == 2'h1 && q[s].size() < DEPTH) q[s].push_back(d);
        if (k == 2'h1) pend = pend + 8'h01;
        waitIdle();
        if (k == 2'h2) begin
            check({7'h00, packetValid}, 8'h01);
            check({6'h00, packetSel}, {6'h00, s});
            check({3'h0, packetLen}, pend);
            pend = 8'h00;
            @(posedge ref_clk);
            commitAck <= 1'b1;
            @(posedge ref_clk);
            commitAck <= 1'b0;
        end
        flags();
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge ref_clk);
        nrst <= 1'b1;
        @(negedge ref_clk);
        flags();
        // drain past empty: the last word must stay on the bus
        for (int i = 0; i < 3; i++) load(2'h1, rnd8());
        for (int i = 0; i < 4; i++) req(2'h0, 2'h1, 8'h00);
        for (int s = 0; s < 4; s++) begin
            for (int i = 0; i < 4; i++) req(2'h1, s[1:0], rnd8());
            req(2'h2, s[1:0], 8'h00);
            for (int i = 0; i < 4; i++) req(2'h0, s[1:0], 8'h00);
        end
        // one write past full is dropped; no commit follows it
        for (int i = 0; i <= DEPTH; i++) req(2'h1, 2'h2, rnd8());
        @(posedge ref_clk);
        loadSel <= 2'h2;
        @(negedge ref_clk);
        check({7'h00, loadReady}, 8'h00);
        repeat (DEPTH) req(2'h0, 2'h2, 8'h00);
        completeRun();
    end
endmodule
`default_nettype wire
